// ===== verilog/clkgen_pkg.sv
/*
  Shared constants for the clock generator configuration controller:
  register offsets, field positions, reset values and timing counts.
  Assumes a 100 MHz system clock and a 16-bit plain register port.
*/
package clkgen_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_OUT = 12;
  localparam int NUM_UPIN = 7;
  localparam int NUM_INTDIV = 5;
  // source codes at the cross point
  localparam logic [3:0] SRC_FRAC0 = 4'h0;
  localparam logic [3:0] SRC_FRAC1 = 4'h1;
  localparam logic [3:0] SRC_REF = 4'h2;
  localparam logic [3:0] SRC_INT0 = 4'h3;
  localparam logic [3:0] SRC_LAST = 4'h7;
  // reference select codes
  localparam logic [1:0] REF_XTAL = 2'h0;
  localparam logic [1:0] REF_EXT_A = 2'h2;
  localparam logic [1:0] REF_EXT_B = 2'h3;
  // universal pin function codes
  localparam logic [2:0] UF_NONE = 3'h0;
  localparam logic [2:0] UF_OE = 3'h1;
  localparam logic [2:0] UF_SSC = 3'h2;
  localparam logic [2:0] UF_REFSEL = 3'h3;
  localparam logic [2:0] UF_FSEL = 3'h4;
  localparam logic [2:0] UF_ADDR = 3'h5;
  // register offsets (word addresses on the plain port)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h01;
  localparam logic [7:0] OFS_REFCFG = 8'h02;
  localparam logic [7:0] OFS_XTAL = 8'h03;
  localparam logic [7:0] OFS_PDIV = 8'h04;
  localparam logic [7:0] OFS_FB_NUM = 8'h05;
  localparam logic [7:0] OFS_FB_DEN = 8'h06;
  localparam logic [7:0] OFS_FR_NUM0 = 8'h08;
  localparam logic [7:0] OFS_FR_DEN0 = 8'h0a;
  localparam logic [7:0] OFS_UPIN0 = 8'h10;
  localparam logic [7:0] OFS_ROUTE0 = 8'h20;
  localparam logic [7:0] OFS_OUTDIV0 = 8'h30;
  // control register fields
  localparam int CTRL_RESTART = 0;
  localparam int CTRL_RECAL = 1;
  localparam int CTRL_REFPIN = 2;
  localparam int CTRL_OE = 3;
  localparam int CTRL_SSC = 4;
  // refcfg fields: [1:0] select, [3:2] fmt a, [5:4] fmt b, [6] dis a, [7] dis b
  localparam int RC_FMT_A = 2;
  localparam int RC_FMT_B = 4;
  localparam int RC_DIS_A = 6;
  localparam int RC_DIS_B = 7;
  // status fields
  localparam int ST_READY = 0;
  localparam int ST_OUT_ON = 1;
  localparam int ST_RECAL = 2;
  localparam int ST_NOREF = 3;
  // crystal load: code n means 2.5 pF + 0.5 pF * n, 0..38 -> 2.5..21.5 pF
  localparam logic [5:0] XTAL_CL_MAX = 6'h26;
  localparam logic [5:0] OUTDIV_MIN = 6'h01;
  localparam logic [5:0] OUTDIV_MAX = 6'h3f;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int RECAL_US = 10;
  localparam int RECAL_CYC = RECAL_US * CLK_MHZ;
  localparam int REF_WAIT_US = 20;
  localparam int REF_WAIT_CYC = REF_WAIT_US * CLK_MHZ;
endpackage

// ===== verilog/nvm_if.sv
/*
  Interface between the sequencer and the nonvolatile loader.
  Assumes both ends share clk.
*/
`timescale 1ns/1ns
interface nvm_if;
  logic start;
  logic busy;
  logic done;
  logic wr;
  logic [7:0] addr;
  logic [15:0] data;
  modport ctrl (output start, input busy, done, wr, addr, data);
  modport loader (input start, output busy, done, wr, addr, data);
endinterface

// ===== verilog/nvm_loader.sv
/*
  Walks a constant default image and emits one register write per cycle.
  Assumes start is a one-cycle pulse from the sequencer.
*/
`timescale 1ns/1ns
module nvm_loader import clkgen_pkg::*; #(
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  nvm_if.loader bus
);
  logic [7:0] img_addr [DEPTH];
  logic [15:0] img_data [DEPTH];
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      img_addr[i] = OFS_OUTDIV0 + 8'(i);
      img_data[i] = 16'h0001;
    end
    img_addr[0] = OFS_CTRL;
    img_data[0] = 16'h0018;
  end
  logic [7:0] idx_reg;
  logic busy_reg;
  logic done_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idx_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (bus.start) begin
        busy_reg <= 1'b1;
        idx_reg <= 8'h00;
      end else if (busy_reg) begin
        if (idx_reg == 8'(DEPTH - 1)) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
        idx_reg <= idx_reg + 8'h01;
      end
    end
  end
  assign bus.busy = busy_reg;
  assign bus.done = done_reg;
  assign bus.wr = busy_reg;
  assign bus.addr = img_addr[idx_reg[2:0]];
  assign bus.data = img_data[idx_reg[2:0]];
endmodule // nvm_loader

// ===== verilog/clock_gen_config_control.sv
/*
  Configuration and sequencing controller of a multi-output clock generator.
  Assumes the register master keeps the plain-port timing, pins are async.
*/
// Operation
// RULE1 - power-up loads defaults from nonvolatile store
// RULE2 - register port closed until initialization done
// RULE3 - outputs squelched during initialization
// RULE4 - power-up option: defaults loaded, outputs disabled
// RULE5 - host writes, restarts sequence without reloading
// RULE6 - reference select by two pins or register
// RULE7 - universal pins assignable to one function
// RULE8 - cross point routes any divider anywhere
// RULE9 - output divider ratio 1 to 63
// RULE10 - four divider groups set frequency plan
// RULE11 - free-run crystal or synchronous external mode
// RULE12 - crystal load cap 2.5 to 21.5 pF
// RULE13 - unused reference inputs disabled by register
// RULE14 - reference input format selectable, four kinds
// RULE15 - config bit picks pin or register select
// RULE16 - no reference at power-up, no outputs
// RULE17 - manual recalibration turns outputs off briefly
// RULE18 - restart squelches outputs until complete
`timescale 1ns/1ns
module clock_gen_config_control import clkgen_pkg::*; #(
  parameter bit OTP_OUTPUTS_OFF = 1'b0,
  parameter int RECAL_CYCLES = RECAL_CYC,
  parameter int REF_WAIT_CYCLES = REF_WAIT_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_UPIN-1:0] univ_pins,
  input wire logic ref_present,
  output logic [NUM_OUT-1:0] out_enable,
  output logic [NUM_OUT*4-1:0] out_source,
  output logic [NUM_OUT*6-1:0] out_divider,
  output logic [1:0] active_ref,
  output logic sync_mode,
  output logic ext_ref_a_on,
  output logic ext_ref_b_on,
  output logic [1:0] ext_ref_a_format,
  output logic [1:0] ext_ref_b_format,
  output logic [5:0] crystal_load_cap,
  output logic [7:0] input_divider,
  output logic [15:0] feedback_ratio_num,
  output logic [15:0] feedback_ratio_den,
  output logic [31:0] fractional_output_ratio_num,
  output logic [31:0] fractional_output_ratio_den,
  output logic spread_enable,
  output logic [1:0] freq_select,
  output logic [1:0] bus_addr_select,
  output logic recal_start,
  output logic ready
);
  typedef enum logic [2:0] {S_LOAD_GO, S_LOAD, S_REFWAIT, S_RUN, S_HOLD, S_RECAL} seq_t;
  seq_t state_reg, state_next;

  function automatic logic [5:0] clamp_div(input logic [5:0] v);
    return (v < OUTDIV_MIN) ? OUTDIV_MIN : v;
  endfunction

  nvm_if nv();
  nvm_loader #(.DEPTH(8)) u_loader (.clk(clk), .reset(reset), .bus(nv));

  // three-stage synchronisers on async pins
  logic [NUM_UPIN-1:0] pin_s1, pin_s2, pin_s3, pin_val;
  logic ref_s1, ref_s2, ref_s3, ref_ok;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_val <= '0;
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      ref_ok <= 1'b0;
    end else begin
      pin_s1 <= univ_pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_val <= (pin_s2 & pin_s3) | (pin_val & (pin_s2 | pin_s3));
      ref_s1 <= ref_present;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      if (ref_s2 == ref_s3) begin
        ref_ok <= ref_s2;
      end
    end
  end

  // register file
  logic [15:0] ctrl_reg, refcfg_reg, pdiv_reg, fbnum_reg, fbden_reg;
  logic [5:0] xtal_reg;
  logic [15:0] frnum_reg [2];
  logic [15:0] frden_reg [2];
  logic [2:0] upin_reg [NUM_UPIN];
  logic [3:0] route_reg [NUM_OUT];
  logic [5:0] odiv_reg [NUM_OUT];

  // host writes only after init; loader writes during it
  wire host_open = (state_reg != S_LOAD_GO) && (state_reg != S_LOAD); // RULE2
  // gate on the registered ready so the port opens in the same cycle the host sees it
  wire host_wr = reg_wr && ready; // RULE2
  wire w_en = host_wr || nv.wr; // RULE1
  wire [7:0] w_addr = nv.wr ? nv.addr : reg_addr;
  wire [15:0] w_data = nv.wr ? nv.data : reg_wdata;
  wire restart_req = host_wr && (reg_addr == OFS_CTRL) && reg_wdata[CTRL_RESTART];
  wire recal_req = host_wr && (reg_addr == OFS_CTRL) && reg_wdata[CTRL_RECAL];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= 16'h0000;
      refcfg_reg <= 16'h0000;
      pdiv_reg <= 16'h0001;
      fbnum_reg <= 16'h0000;
      fbden_reg <= 16'h0001;
      xtal_reg <= 6'h00;
      for (int i = 0; i < 2; i++) begin
        frnum_reg[i] <= 16'h0000;
        frden_reg[i] <= 16'h0001;
      end
      for (int i = 0; i < NUM_UPIN; i++) upin_reg[i] <= UF_NONE;
      for (int i = 0; i < NUM_OUT; i++) begin
        route_reg[i] <= SRC_FRAC0;
        odiv_reg[i] <= OUTDIV_MIN;
      end
    end else if (w_en) begin
      unique case (w_addr)
        OFS_CTRL: ctrl_reg <= {w_data[15:2], 2'b00};
        OFS_REFCFG: refcfg_reg <= w_data; // RULE13
        OFS_XTAL: xtal_reg <= (w_data[5:0] > XTAL_CL_MAX) ? XTAL_CL_MAX : w_data[5:0]; // RULE12
        OFS_PDIV: pdiv_reg <= w_data; // RULE10
        OFS_FB_NUM: fbnum_reg <= w_data; // RULE10
        OFS_FB_DEN: fbden_reg <= w_data; // RULE10
        OFS_FR_NUM0: frnum_reg[0] <= w_data; // RULE10
        OFS_FR_NUM0 + 8'h01: frnum_reg[1] <= w_data;
        OFS_FR_DEN0: frden_reg[0] <= w_data;
        OFS_FR_DEN0 + 8'h01: frden_reg[1] <= w_data;
        default: begin
          for (int i = 0; i < NUM_UPIN; i++)
            if (w_addr == OFS_UPIN0 + 8'(i)) upin_reg[i] <= w_data[2:0]; // RULE7
          for (int i = 0; i < NUM_OUT; i++) begin
            if (w_addr == OFS_ROUTE0 + 8'(i)) // RULE8
              route_reg[i] <= (w_data[3:0] > SRC_LAST) ? SRC_LAST : w_data[3:0];
            if (w_addr == OFS_OUTDIV0 + 8'(i)) odiv_reg[i] <= clamp_div(w_data[5:0]); // RULE9
          end
        end
      endcase
    end
  end

  // universal pin functions, first pin of each two-bit function wins lower bit
  logic pin_oe_any, pin_oe_val, pin_ssc;
  logic [1:0] pin_refsel, pin_fsel, pin_addr;
  always_comb begin
    int r, f, a;
    r = 0;
    f = 0;
    a = 0;
    pin_oe_any = 1'b0;
    pin_oe_val = 1'b1;
    pin_ssc = 1'b0;
    pin_refsel = 2'b00;
    pin_fsel = 2'b00;
    pin_addr = 2'b00;
    for (int i = 0; i < NUM_UPIN; i++) begin
      unique case (upin_reg[i]) // RULE7
        UF_OE: begin
          pin_oe_any = 1'b1;
          pin_oe_val = pin_oe_val & pin_val[i];
        end
        UF_SSC: pin_ssc = pin_val[i];
        UF_REFSEL: begin
          if (r < 2) pin_refsel[r] = pin_val[i];
          r = r + 1;
        end
        UF_FSEL: begin
          if (f < 2) pin_fsel[f] = pin_val[i];
          f = f + 1;
        end
        UF_ADDR: begin
          if (a < 2) pin_addr[a] = pin_val[i];
          a = a + 1;
        end
        default: ;
      endcase
    end
  end

  // pin or register reference select
  wire [1:0] ref_sel = ctrl_reg[CTRL_REFPIN] ? pin_refsel : refcfg_reg[1:0]; // RULE6 RULE15
  wire is_sync = (ref_sel == REF_EXT_A) || (ref_sel == REF_EXT_B); // RULE11
  wire sw_oe = ctrl_reg[CTRL_OE] && (!pin_oe_any || pin_oe_val);

  // sequencer
  logic [15:0] cnt_reg, cnt_next;
  logic hold_reg;
  wire [15:0] recal_last = 16'(RECAL_CYCLES - 1);
  wire [15:0] refwait_last = 16'(REF_WAIT_CYCLES - 1);
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 16'h0001;
    unique case (state_reg)
      S_LOAD_GO: state_next = S_LOAD; // RULE1
      S_LOAD: if (nv.done) state_next = S_REFWAIT;
      S_REFWAIT: begin
        if (ref_ok) state_next = hold_reg ? S_HOLD : S_RUN; // RULE4 RULE16
        else if (cnt_reg == refwait_last) cnt_next = cnt_reg; // RULE16
      end
      S_RUN, S_HOLD: begin
        cnt_next = 16'h0000;
        if (restart_req) state_next = S_REFWAIT; // RULE5 RULE18
        else if (recal_req && state_reg == S_RUN) state_next = S_RECAL; // RULE17 RULE4
      end
      S_RECAL: if (cnt_reg == recal_last) state_next = S_RUN; // RULE17
    endcase
    if (state_next != state_reg) cnt_next = 16'h0000;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= S_LOAD_GO;
      cnt_reg <= 16'h0000;
      hold_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (state_reg == S_LOAD_GO) hold_reg <= OTP_OUTPUTS_OFF; // RULE4
      else if (restart_req) hold_reg <= 1'b0; // RULE5
    end
  end
  assign nv.start = (state_reg == S_LOAD_GO);

  wire outs_live = (state_reg == S_RUN) && ref_ok; // RULE3 RULE16 RULE18
  wire [15:0] status_word = {12'h000, !ref_ok, state_reg == S_RECAL, outs_live, host_open};

  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (reg_addr)
      OFS_CTRL: rd_mux = ctrl_reg;
      OFS_STATUS: rd_mux = status_word;
      OFS_REFCFG: rd_mux = refcfg_reg;
      OFS_XTAL: rd_mux = {10'h000, xtal_reg};
      OFS_PDIV: rd_mux = pdiv_reg;
      OFS_FB_NUM: rd_mux = fbnum_reg;
      OFS_FB_DEN: rd_mux = fbden_reg;
      OFS_FR_NUM0: rd_mux = frnum_reg[0];
      OFS_FR_NUM0 + 8'h01: rd_mux = frnum_reg[1];
      OFS_FR_DEN0: rd_mux = frden_reg[0];
      OFS_FR_DEN0 + 8'h01: rd_mux = frden_reg[1];
      default: begin
        for (int i = 0; i < NUM_UPIN; i++)
          if (reg_addr == OFS_UPIN0 + 8'(i)) rd_mux = {13'h0000, upin_reg[i]};
        for (int i = 0; i < NUM_OUT; i++) begin
          if (reg_addr == OFS_ROUTE0 + 8'(i)) rd_mux = {12'h000, route_reg[i]};
          if (reg_addr == OFS_OUTDIV0 + 8'(i)) rd_mux = {10'h000, odiv_reg[i]};
        end
      end
    endcase
  end

  logic [NUM_OUT*4-1:0] src_flat;
  logic [NUM_OUT*6-1:0] div_flat;
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_flat
    assign src_flat[g*4 +: 4] = route_reg[g]; // RULE8
    assign div_flat[g*6 +: 6] = odiv_reg[g]; // RULE9
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
      out_enable <= '0;
      out_source <= '0;
      out_divider <= '0;
      active_ref <= REF_XTAL;
      sync_mode <= 1'b0;
      ext_ref_a_on <= 1'b0;
      ext_ref_b_on <= 1'b0;
      ext_ref_a_format <= 2'h0;
      ext_ref_b_format <= 2'h0;
      crystal_load_cap <= 6'h00;
      input_divider <= 8'h00;
      feedback_ratio_num <= 16'h0000;
      feedback_ratio_den <= 16'h0000;
      fractional_output_ratio_num <= 32'h00000000;
      fractional_output_ratio_den <= 32'h00000000;
      spread_enable <= 1'b0;
      freq_select <= 2'h0;
      bus_addr_select <= 2'h0;
      recal_start <= 1'b0;
      ready <= 1'b0;
    end else begin
      reg_rdata <= (reg_rd && ready) ? rd_mux : 16'h0000; // RULE2
      out_enable <= {NUM_OUT{outs_live && sw_oe}}; // RULE3 RULE4 RULE17
      out_source <= src_flat;
      out_divider <= div_flat;
      active_ref <= ref_sel; // RULE6
      sync_mode <= is_sync; // RULE11
      ext_ref_a_on <= !refcfg_reg[RC_DIS_A]; // RULE13
      ext_ref_b_on <= !refcfg_reg[RC_DIS_B]; // RULE13
      ext_ref_a_format <= refcfg_reg[RC_FMT_A +: 2]; // RULE14
      ext_ref_b_format <= refcfg_reg[RC_FMT_B +: 2]; // RULE14
      crystal_load_cap <= xtal_reg; // RULE12
      input_divider <= pdiv_reg[7:0];
      feedback_ratio_num <= fbnum_reg;
      feedback_ratio_den <= fbden_reg;
      fractional_output_ratio_num <= {frnum_reg[1], frnum_reg[0]};
      fractional_output_ratio_den <= {frden_reg[1], frden_reg[0]};
      spread_enable <= ctrl_reg[CTRL_SSC] | pin_ssc; // RULE7
      freq_select <= pin_fsel;
      bus_addr_select <= pin_addr;
      recal_start <= recal_req && (state_reg == S_RUN); // RULE17
      ready <= host_open;
    end
  end
endmodule // clock_gen_config_control

// ===== bench/clkgen_assertions.sv
/* checker for the clock generator controller: port timing and sequencing
   bound to the top module, sees only its ports */
`timescale 1ns/1ns
module clkgen_checker import clkgen_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic ref_present,
  input wire logic [NUM_OUT-1:0] out_enable,
  input wire logic [1:0] active_ref,
  input wire logic sync_mode,
  input wire logic recal_start,
  input wire logic ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_ready_bound: assert property ($fell(reset) |-> ##[1:20] ready)
    else $error("port not open in time after reset");
  a_port_closed: assert property ((reg_rd && !ready) |=> reg_rdata == '0)
    else $error("read answered before init done");
  a_status_ready: assert property ((reg_rd && ready && reg_addr == OFS_STATUS)
    |=> reg_rdata[ST_READY]) else $error("status lacks ready bit");
  a_init_squelch: assert property (!ready |-> out_enable == '0)
    else $error("outputs live during init");
  // three sync flops, the ref_ok flop and the output register fit inside six samples
  a_noref_dark: assert property (!ref_present [*6] |-> out_enable == '0)
    else $error("outputs live without reference");
  a_recal_dark: assert property (recal_start |=> ##1 (out_enable == '0) [*8])
    else $error("outputs live during recalibration");
  a_recal_ready: assert property (recal_start |-> ready)
    else $error("recalibration before init done");
  a_mode_tracks: assert property ((ready && $stable(active_ref)) [*2]
    |-> sync_mode == active_ref[1]) else $error("mode disagrees with source");
  c_ready: cover property ($rose(ready));
  c_recal: cover property (recal_start);
  c_read: cover property (reg_rd && ready);
endmodule // clkgen_checker

bind clock_gen_config_control clkgen_checker u_chk (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_present(ref_present),
  .out_enable(out_enable), .active_ref(active_ref), .sync_mode(sync_mode),
  .recal_start(recal_start), .ready(ready));

// ===== bench/host_model.sv
/* host on the register port: single-cycle strobes, no wait states
   assumes callers enter its tasks just after a rising clock edge */
`timescale 1ns/1ns
module host_model import clkgen_pkg::*; (
  input wire logic clk,
  input wire logic ready,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // strobes stay up so back-to-back calls never assign twice in one step
  task automatic access(input bit w, input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
  endtask
  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_wdata <= ~reg_wdata;
    @(posedge clk);
  endtask
  task automatic wait_ready(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 60 && !ok; i++) begin
      @(posedge clk);
      ok = (ready === 1'b1);
    end
  endtask
  task automatic restart(input logic [15:0] d);
    access(1'b1, OFS_CTRL, d | 16'h0001);
    idle();
  endtask
  task automatic recal();
    access(1'b1, OFS_CTRL, 16'h000a);
    idle();
  endtask
endmodule // host_model

// ===== bench/tb_top.sv
/* self-checking bench for the controller in its outputs-off power-up mode
   reads are queued and checked by a monitor one cycle after the strobe */
`timescale 1ns/1ns
module tb_top import clkgen_pkg::*;;
  localparam int RC = 20;
  logic clk, reset, ref_present, reg_wr, reg_rd, ready, sync_mode, recal_start;
  logic ext_ref_a_on, ext_ref_b_on, spread_enable, ok;
  logic [7:0] reg_addr, input_divider;
  logic [15:0] reg_wdata, reg_rdata, feedback_ratio_num, feedback_ratio_den;
  logic [6:0] univ_pins;
  logic [11:0] out_enable;
  logic [47:0] out_source;
  logic [71:0] out_divider;
  logic [1:0] active_ref, ext_ref_a_format, ext_ref_b_format, freq_select, bus_addr_select;
  logic [5:0] crystal_load_cap;
  logic [31:0] fractional_output_ratio_num, fractional_output_ratio_den;
  logic [15:0] rq[$];
  logic [15:0] fd[5];
  logic [5:0] dv[12];
  logic [3:0] sv[12];
  logic [7:0] rc;
  logic rd_d = 1'b0;
  int failures = 0;
  int checks = 0;
  clock_gen_config_control #(.OTP_OUTPUTS_OFF(1'b1), .RECAL_CYCLES(RC),
    .REF_WAIT_CYCLES(20)) u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .univ_pins(univ_pins), .ref_present(ref_present), .out_enable(out_enable),
    .out_source(out_source), .out_divider(out_divider), .active_ref(active_ref),
    .sync_mode(sync_mode), .ext_ref_a_on(ext_ref_a_on), .ext_ref_b_on(ext_ref_b_on),
    .ext_ref_a_format(ext_ref_a_format), .ext_ref_b_format(ext_ref_b_format),
    .crystal_load_cap(crystal_load_cap), .input_divider(input_divider),
    .feedback_ratio_num(feedback_ratio_num), .feedback_ratio_den(feedback_ratio_den),
    .fractional_output_ratio_num(fractional_output_ratio_num),
    .fractional_output_ratio_den(fractional_output_ratio_den),
    .spread_enable(spread_enable), .freq_select(freq_select),
    .bus_addr_select(bus_addr_select), .recal_start(recal_start), .ready(ready));
  host_model u_host (.clk(clk), .ready(ready), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  always #5 clk = ~clk;
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk("rdata", rq.pop_front(), reg_rdata);
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rq.push_back(e);
    u_host.access(1'b0, a, 16'h0000);
  endtask
  task automatic wait_for(input logic [11:0] v, input int lim);
    int n;
    n = 0;
    u_host.idle();
    while (out_enable !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("out_enable", v, out_enable);
    if (n >= lim) tally_and_finish();
  endtask
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    univ_pins = '0;
    ref_present = 1'b1;
    void'($urandom(90993));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(OFS_STATUS, 16'h0000);
    u_host.idle();
    u_host.wait_ready(ok);
    if (!ok) begin
      failures++;
      tally_and_finish();
    end
    repeat (8) @(posedge clk);
    chk("hold_oe", 12'h000, out_enable);
    chk("spread", 1, spread_enable);
    chk("div0", 1, out_divider[5:0]);
    foreach (fd[i]) begin
      fd[i] = 16'($urandom);
      wr(8'(i + (i > 2 ? 5 : 4) + (i > 3 ? 1 : 0)), fd[i]);
    end
    wr(OFS_FR_NUM0 + 8'h01, fd[4]);
    wr(OFS_FR_DEN0 + 8'h01, fd[3]);
    for (int i = 0; i < 12; i++) begin
      dv[i] = (i == 11) ? 6'h01 : 6'($urandom_range(63, 1));
      sv[i] = 4'($urandom_range(7, 0));
      wr(OFS_OUTDIV0 + 8'(i), (i == 11) ? 16'h0000 : 16'(dv[i]));
      wr(OFS_ROUTE0 + 8'(i), 16'(sv[i]));
    end
    u_host.idle();
    u_host.restart(16'h0008);
    wait_for(12'hfff, 60);
    chk("pdiv", fd[0][7:0], input_divider);
    chk("fbnum", fd[1], feedback_ratio_num);
    chk("fbden", fd[2], feedback_ratio_den);
    chk("frnum", fd[3], fractional_output_ratio_num[15:0]);
    chk("frden", fd[4], fractional_output_ratio_den[15:0]);
    chk("frnum1", fd[4], fractional_output_ratio_num[31:16]);
    chk("frden1", fd[3], fractional_output_ratio_den[31:16]);
    for (int i = 0; i < 12; i++) begin
      chk("outdiv", dv[i], out_divider[i*6 +: 6]);
      chk("route", sv[i], out_source[i*4 +: 4]);
    end
    rd(OFS_STATUS, 16'h0003);
    rd(8'hff, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      rc = 8'($urandom) & 8'hfc | 8'(k == 0 ? REF_XTAL : k == 1 ? REF_EXT_A : REF_EXT_B);
      wr(OFS_REFCFG, 16'(rc));
      repeat (3) u_host.idle();
      chk("ref", rc[1:0], active_ref);
      chk("sync", rc[1], sync_mode);
      chk("fmt", rc[5:2], {ext_ref_b_format, ext_ref_a_format});
      chk("on", 2'(~rc[7:6]), {ext_ref_b_on, ext_ref_a_on});
    end
    wr(OFS_REFCFG, 16'h0000);
    wr(OFS_UPIN0, 16'h0003);
    wr(OFS_UPIN0 + 8'h01, 16'h0003);
    wr(OFS_CTRL, 16'h000c);
    univ_pins <= 7'h03;
    repeat (8) u_host.idle();
    chk("pinref", REF_EXT_B, active_ref);
    univ_pins <= 7'h00;
    repeat (8) u_host.idle();
    chk("pinref", REF_XTAL, active_ref);
    for (int i = 0; i < 7; i++)
      wr(OFS_UPIN0 + 8'(i), 16'({UF_SSC, UF_NONE, UF_OE, UF_FSEL, UF_FSEL, UF_ADDR,
        UF_ADDR} >> (3 * (6 - i)) & 21'h7));
    wr(OFS_CTRL, 16'h0008);
    univ_pins <= 7'h79;
    wait_for(12'h000, 20);
    univ_pins <= 7'h7d;
    wait_for(12'hfff, 20);
    chk("ssc", 1, spread_enable);
    chk("fsel", 2'h3, freq_select);
    chk("addr", 2'h3, bus_addr_select);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_XTAL, i == 0 ? 16'd0 : i == 1 ? 16'd38 : 16'd50);
      repeat (2) u_host.idle();
      chk("xtal", i == 0 ? 6'd0 : XTAL_CL_MAX, crystal_load_cap);
    end
    ref_present <= 1'b0;
    wait_for(12'h000, 10);
    rd(OFS_STATUS, 16'h0009);
    ref_present <= 1'b1;
    wait_for(12'hfff, 20);
    u_host.recal();
    wait_for(12'h000, 5);
    repeat (RC - 6) @(posedge clk);
    chk("recal_off", 12'h000, out_enable);
    wait_for(12'hfff, 20);
    u_host.restart(16'h0008);
    wait_for(12'h000, 5);
    wait_for(12'hfff, 60);
    chk("kept", fd[1], feedback_ratio_num);
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule // tb_top
